// ===== logic/kpr_debounce.sv
// Whole-keypad debouncer: any change restarts the settle time.
// Assumes synchronous key levels and a unit tick restarted by restart.
`timescale 1ns/1ps
module kpr_debounce (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [kpr_pkg::NUM_KEYS-1:0] raw,
   input wire logic [7:0] settle,
   input wire logic unit_tick,
   output logic restart,
   output logic [kpr_pkg::NUM_KEYS-1:0] stable
);
   logic [kpr_pkg::NUM_KEYS-1:0] sample_r;
   logic [kpr_pkg::NUM_KEYS-1:0] stable_r;
   logic [7:0] units_r;

   assign restart = raw != sample_r;
   assign stable = stable_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sample_r <= '0;
         units_r <= 8'h00;
      end else if (restart) begin
         sample_r <= raw;
         units_r <= 8'h00;
      end else if (unit_tick && units_r < settle) begin
         units_r <= units_r + 8'h01;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stable_r <= '0;
      end else if (!restart && units_r >= settle) begin
         stable_r <= sample_r;
      end
   end

   AST_SETTLE: assert property (@(posedge clk) disable iff (!rst_n)
      !$stable(stable_r) |-> $past(units_r >= settle && !restart))
      else $error("key state moved before settle time");
endmodule

// ===== logic/kpr_pkg.sv
// Shared constants of the keypad report controller.
// Assumes a 250 MHz clock; the command stream arrives over Wishbone.
package kpr_pkg;
   localparam int CLK_MHZ = 250;
   localparam int DEB_UNIT_US = 6554;
   localparam int DEB_UNIT_CYC = DEB_UNIT_US * CLK_MHZ;
   localparam int RPT_UNIT_MS = 100;
   localparam int RPT_UNIT_CYC = RPT_UNIT_MS * 1000 * CLK_MHZ;
   localparam int NUM_KEYS = 25;
   localparam int BUF_DEPTH = 10;
   localparam logic [3:0] BUF_FULL_CNT = 4'ha;
   localparam logic [3:0] BUF_LAST = 4'h9;
   localparam logic [5:0] CODE_LAST = 6'h31;
   localparam logic [5:0] UP_FIRST = 6'h19;
   localparam logic [7:0] CMD_PREFIX = 8'hfe;
   localparam logic [7:0] OP_AUTO_ON = 8'h41;
   localparam logic [7:0] OP_AUTO_OFF = 8'h4f;
   localparam logic [7:0] OP_POLL = 8'h26;
   localparam logic [7:0] OP_CLR_BUF = 8'h45;
   localparam logic [7:0] OP_DEBOUNCE = 8'h55;
   localparam logic [7:0] OP_RPT_MODE = 8'h7e;
   localparam logic [7:0] OP_RPT_OFF = 8'h60;
   localparam logic [7:0] OP_ASSIGN = 8'hd5;
   localparam logic [7:0] OP_TM_DELAY = 8'h9f;
   localparam logic [7:0] OP_TM_INTVL = 8'h9e;
   localparam logic [7:0] MODE_HOLD = 8'h01;
   localparam logic [7:0] MODE_TYPEMATIC = 8'h00;
   localparam logic [7:0] KEEP_CODE = 8'hff;
   localparam logic [7:0] DOWN_BASE = 8'h41;
   localparam logic [7:0] UP_BASE = 8'h61;
   localparam logic [7:0] DEB_RST = 8'h08;
   localparam logic [7:0] DELAY_RST = 8'h0a;
   localparam logic [7:0] INTVL_RST = 8'h02;
   localparam int ADR_W = 5;
   localparam logic [4:0] REG_CMD = 5'h00;
   localparam logic [4:0] REG_TX = 5'h04;
   localparam logic [4:0] REG_STATUS = 5'h08;
   localparam logic [4:0] REG_IRQ_EN = 5'h0c;
   localparam logic [4:0] REG_IRQ_CLR = 5'h10;
   localparam logic [4:0] REG_STATE = 5'h14;
   localparam logic [4:0] REG_CFG = 5'h18;
   localparam int IRQ_TX = 0;
   localparam int IRQ_KEY = 1;
   localparam int IRQ_OVR = 2;
   localparam int IRQ_DROP = 3;
   localparam int IRQ_W = 4;
   typedef enum logic [1:0] {KPR_IDLE, KPR_OPC, KPR_ARG, KPR_CODES} kpr_cmd_state_type;
endpackage

// ===== logic/kpr_tick.sv
// Free-running period tick with restart.
// Assumes rst_n is already synchronised to clk.
`timescale 1ns/1ps
module kpr_tick #(
   parameter int PERIOD = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clr,
   output logic tick
);
   localparam int W = $clog2(PERIOD + 1);
   logic [W-1:0] cnt_r;

   assign tick = !clr && (cnt_r == W'(PERIOD - 1));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
      end else if (clr || tick) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + 1'b1;
      end
   end
endmodule

// ===== logic/kpr_top.sv
// Keypad report controller: command interpreter, key tracking, buffer.
// Assumes a Wishbone classic master and synchronous key inputs.
// Operation
// - Auto-transmit-on command sends each key report to host at once; reset default.
// - Auto-transmit-off command stores reports in a ten-entry buffer instead.
// - Poll returns next stored code; top bit set while more keys remain.
// - Poll with an empty buffer returns a zero byte.
// - Clear-buffer command empties the key buffer.
// - Debounce wait is setting times 6.554 ms; setting defaults to 8.
// - Repeat-mode argument 1 selects hold, 0 typematic; typematic after reset.
// - Typematic: report at once, then repeat after delay at set interval.
// - Hold mode: key-down code once on press, key-up code on release.
// - Auto-repeat-off command disables repeats; typematic repeat is on after reset.
// - Assignment takes 25 down then 25 up codes; 255 keeps the code.
// - Reset codes: down 65..89, up 97..121 for keys in order.
// - Typematic delay in 100 ms units, default 10.
// - Typematic interval in 100 ms units, default 2.
//
// Our own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
module kpr_top #(
   parameter int DEB_UNIT_CYC = kpr_pkg::DEB_UNIT_CYC,
   parameter int RPT_UNIT_CYC = kpr_pkg::RPT_UNIT_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_we,
   input wire logic [kpr_pkg::ADR_W-1:0] wb_adr,
   input wire logic [3:0] wb_sel,
   input wire logic [31:0] wb_dat_wr,
   output logic [31:0] wb_dat_rd,
   output logic wb_ack,
   input wire logic [kpr_pkg::NUM_KEYS-1:0] key_pressed,
   output logic irq
);
   logic [1:0] rst_sync_r;
   logic rst_s_n, wb_ack_r, wb_req, wb_wr, wb_rd, cmd_vld;
   logic [31:0] wb_dat_r, rd_nxt;
   logic [7:0] cmd_byte, opc_r;
   kpr_pkg::kpr_cmd_state_type state_r;
   logic [5:0] code_idx_r;
   logic op_hit, arg_hit, code_hit, poll_req, clr_req;
   logic auto_tx_r, rpt_on_r, hold_r;
   logic [7:0] deb_time_r, tm_delay_r, tm_intvl_r;
   logic [7:0] down_r [kpr_pkg::NUM_KEYS];
   logic [7:0] up_r [kpr_pkg::NUM_KEYS];
   logic deb_restart, deb_tick, rpt_tick, active_r, rpt_first_r;
   logic [kpr_pkg::NUM_KEYS-1:0] key_stable;
   logic [4:0] act_idx_r, new_idx;
   logic [7:0] rpt_cnt_r, rpt_target, rep_code, poll_byte, tx_data_r, tx_byte;
   logic press, release_ev, typematic, rpt_fire, rep_vld;
   logic [7:0] buf_r [kpr_pkg::BUF_DEPTH];
   logic [3:0] wr_ptr_r, rd_ptr_r, cnt_r;
   logic push, pop, drop, tx_full_r, tx_load, tx_pop, tx_take, ovr;
   logic [kpr_pkg::IRQ_W-1:0] irq_st_r, irq_en_r, irq_ev, irq_clr;

   // Reset released through two flops; everything else uses the copy
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_r <= 2'b00;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_s_n = rst_sync_r[1];
   // Wishbone slave: one wait state, ack for every address
   assign wb_req = wb_cyc && wb_stb && !wb_ack_r;
   assign wb_wr = wb_req && wb_we && wb_sel[0];
   assign wb_rd = wb_req && !wb_we;
   assign wb_ack = wb_ack_r;
   assign wb_dat_rd = wb_dat_r;
   always_comb begin
      case (wb_adr)
         kpr_pkg::REG_TX: rd_nxt = {23'h000000, tx_full_r, tx_data_r};
         kpr_pkg::REG_STATUS: rd_nxt = {28'h0000000, irq_st_r};
         kpr_pkg::REG_IRQ_EN: rd_nxt = {28'h0000000, irq_en_r};
         kpr_pkg::REG_STATE: rd_nxt = {24'h000000, cnt_r, active_r, hold_r, rpt_on_r, auto_tx_r};
         kpr_pkg::REG_CFG: rd_nxt = {8'h00, tm_intvl_r, tm_delay_r, deb_time_r};
         default: rd_nxt = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         wb_ack_r <= 1'b0;
         wb_dat_r <= 32'h00000000;
      end else begin
         wb_ack_r <= wb_req;
         if (wb_rd) begin
            wb_dat_r <= rd_nxt;
         end
      end
   end

   // Command stream: one byte per write to the command register
   assign cmd_vld = wb_wr && (wb_adr == kpr_pkg::REG_CMD);
   assign cmd_byte = wb_dat_wr[7:0];
   assign op_hit = cmd_vld && (state_r == kpr_pkg::KPR_OPC);
   assign arg_hit = cmd_vld && (state_r == kpr_pkg::KPR_ARG);
   assign code_hit = cmd_vld && (state_r == kpr_pkg::KPR_CODES);
   assign poll_req = op_hit && (cmd_byte == kpr_pkg::OP_POLL);
   assign clr_req = op_hit && (cmd_byte == kpr_pkg::OP_CLR_BUF);
   // Bytes outside a prefixed sequence belong to text, ignored here
   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         state_r <= kpr_pkg::KPR_IDLE;
         opc_r <= 8'h00;
         code_idx_r <= 6'h00;
      end else begin
         case (state_r)
            kpr_pkg::KPR_IDLE: begin
               if (cmd_vld && cmd_byte == kpr_pkg::CMD_PREFIX) begin
                  state_r <= kpr_pkg::KPR_OPC;
               end
            end
            kpr_pkg::KPR_OPC: begin
               if (cmd_vld) begin
                  opc_r <= cmd_byte;
                  code_idx_r <= 6'h00;
                  case (cmd_byte)
                     kpr_pkg::OP_DEBOUNCE, kpr_pkg::OP_RPT_MODE,
                     kpr_pkg::OP_TM_DELAY, kpr_pkg::OP_TM_INTVL: state_r <= kpr_pkg::KPR_ARG;
                     kpr_pkg::OP_ASSIGN: state_r <= kpr_pkg::KPR_CODES;
                     default: state_r <= kpr_pkg::KPR_IDLE;
                  endcase
               end
            end
            kpr_pkg::KPR_ARG: begin
               if (cmd_vld) begin
                  state_r <= kpr_pkg::KPR_IDLE;
               end
            end
            kpr_pkg::KPR_CODES: begin
               if (cmd_vld) begin
                  if (code_idx_r == kpr_pkg::CODE_LAST) begin
                     state_r <= kpr_pkg::KPR_IDLE;
                  end else begin
                     code_idx_r <= code_idx_r + 6'h01;
                  end
               end
            end
            default: state_r <= kpr_pkg::KPR_IDLE;
         endcase
      end
   end

   // Mode and timing settings
   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         auto_tx_r <= 1'b1;
         rpt_on_r <= 1'b1;
         hold_r <= 1'b0;
         deb_time_r <= kpr_pkg::DEB_RST;
         tm_delay_r <= kpr_pkg::DELAY_RST;
         tm_intvl_r <= kpr_pkg::INTVL_RST;
      end else if (op_hit) begin
         case (cmd_byte)
            kpr_pkg::OP_AUTO_ON: auto_tx_r <= 1'b1;
            kpr_pkg::OP_AUTO_OFF: auto_tx_r <= 1'b0;
            kpr_pkg::OP_RPT_OFF: rpt_on_r <= 1'b0;
            default: hold_r <= hold_r;
         endcase
      end else if (arg_hit) begin
         case (opc_r)
            kpr_pkg::OP_DEBOUNCE: deb_time_r <= cmd_byte;
            kpr_pkg::OP_TM_DELAY: tm_delay_r <= cmd_byte;
            kpr_pkg::OP_TM_INTVL: tm_intvl_r <= cmd_byte;
            kpr_pkg::OP_RPT_MODE: begin
               // Choosing a mode also turns repeat back on; other values ignored
               if (cmd_byte == kpr_pkg::MODE_HOLD || cmd_byte == kpr_pkg::MODE_TYPEMATIC) begin
                  hold_r <= cmd_byte == kpr_pkg::MODE_HOLD;
                  rpt_on_r <= 1'b1;
               end
            end
            default: hold_r <= hold_r;
         endcase
      end
   end

   // Key code tables
   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         for (int i = 0; i < kpr_pkg::NUM_KEYS; i++) begin
            down_r[i] <= kpr_pkg::DOWN_BASE + 8'(i);
            up_r[i] <= kpr_pkg::UP_BASE + 8'(i);
         end
      end else if (code_hit && cmd_byte != kpr_pkg::KEEP_CODE) begin
         if (code_idx_r < kpr_pkg::UP_FIRST) begin
            down_r[code_idx_r[4:0]] <= cmd_byte;
         end else begin
            up_r[5'(code_idx_r - kpr_pkg::UP_FIRST)] <= cmd_byte;
         end
      end
   end

   kpr_tick #(.PERIOD(DEB_UNIT_CYC)) u_deb_tick (.clk(clk), .rst_n(rst_s_n), .clr(deb_restart),
      .tick(deb_tick));
   kpr_debounce u_debounce (.clk(clk), .rst_n(rst_s_n), .raw(key_pressed), .settle(deb_time_r),
      .unit_tick(deb_tick), .restart(deb_restart), .stable(key_stable));
   // Repeat timebase restarts on a press so the first delay is exact
   kpr_tick #(.PERIOD(RPT_UNIT_CYC)) u_rpt_tick (.clk(clk), .rst_n(rst_s_n), .clr(press),
      .tick(rpt_tick));
   // Only one key is tracked at a time; lowest index wins a tie
   always_comb begin
      new_idx = 5'h00;
      for (int i = kpr_pkg::NUM_KEYS - 1; i >= 0; i--) begin
         if (key_stable[i]) begin
            new_idx = 5'(i);
         end
      end
   end

   assign press = !active_r && (|key_stable);
   assign release_ev = active_r && !key_stable[act_idx_r];
   assign typematic = rpt_on_r && !hold_r;
   assign rpt_target = rpt_first_r ? tm_delay_r : tm_intvl_r;
   assign rpt_fire = active_r && !release_ev && typematic && rpt_tick &&
                     ({1'b0, rpt_cnt_r} + 9'h001 >= {1'b0, rpt_target});
   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         active_r <= 1'b0;
         act_idx_r <= 5'h00;
         rpt_cnt_r <= 8'h00;
         rpt_first_r <= 1'b1;
      end else if (press) begin
         active_r <= 1'b1;
         act_idx_r <= new_idx;
         rpt_cnt_r <= 8'h00;
         rpt_first_r <= 1'b1;
      end else if (release_ev) begin
         active_r <= 1'b0;
      end else if (active_r && rpt_tick) begin
         if (rpt_fire) begin
            rpt_cnt_r <= 8'h00;
            rpt_first_r <= 1'b0;
         end else if (rpt_cnt_r != 8'hff) begin
            rpt_cnt_r <= rpt_cnt_r + 8'h01;
         end
      end
   end

   assign rep_vld = press || rpt_fire || (release_ev && hold_r && rpt_on_r);
   assign rep_code = press ? down_r[new_idx] :
                     rpt_fire ? down_r[act_idx_r] : up_r[act_idx_r];
   // Key buffer; a report in the clear cycle survives the clear
   assign push = rep_vld && !auto_tx_r && (clr_req || cnt_r != kpr_pkg::BUF_FULL_CNT);
   assign drop = rep_vld && !auto_tx_r && !push;
   assign pop = poll_req && (cnt_r != 4'h0);
   assign poll_byte = (cnt_r == 4'h0) ? 8'h00 :
                      {cnt_r > 4'h1, buf_r[rd_ptr_r][6:0]};
   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         for (int i = 0; i < kpr_pkg::BUF_DEPTH; i++) begin
            buf_r[i] <= 8'h00;
         end
      end else if (push) begin
         buf_r[wr_ptr_r] <= rep_code;
      end
   end

   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         wr_ptr_r <= 4'h0;
         rd_ptr_r <= 4'h0;
         cnt_r <= 4'h0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == kpr_pkg::BUF_LAST) ? 4'h0 : wr_ptr_r + 4'h1;
         end
         if (clr_req) begin
            rd_ptr_r <= wr_ptr_r;
            cnt_r <= {3'h0, push};
         end else begin
            if (pop) begin
               rd_ptr_r <= (rd_ptr_r == kpr_pkg::BUF_LAST) ? 4'h0 : rd_ptr_r + 4'h1;
            end
            cnt_r <= cnt_r + {3'h0, push} - {3'h0, pop};
         end
      end
   end

   // Single transmit holding byte; host drains it by reading REG_TX
   assign tx_load = poll_req || (rep_vld && auto_tx_r);
   assign tx_byte = poll_req ? poll_byte : rep_code;
   assign tx_pop = wb_rd && (wb_adr == kpr_pkg::REG_TX);
   assign tx_take = tx_load && (!tx_full_r || tx_pop);
   assign ovr = (tx_load && !tx_take) || (poll_req && rep_vld && auto_tx_r);
   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         tx_full_r <= 1'b0;
         tx_data_r <= 8'h00;
      end else if (tx_take) begin
         tx_full_r <= 1'b1;
         tx_data_r <= tx_byte;
      end else if (tx_pop) begin
         tx_full_r <= 1'b0;
      end
   end

   // Interrupts: sticky status, set beats clear
   assign irq_ev = {drop, ovr, rep_vld, tx_take};
   assign irq_clr = (wb_wr && wb_adr == kpr_pkg::REG_IRQ_CLR) ? wb_dat_wr[3:0] : 4'h0;
   assign irq = |(irq_st_r & irq_en_r);
   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         irq_st_r <= 4'h0;
         irq_en_r <= 4'h0;
      end else begin
         irq_st_r <= (irq_st_r & ~irq_clr) | irq_ev;
         if (wb_wr && wb_adr == kpr_pkg::REG_IRQ_EN) begin
            irq_en_r <= wb_dat_wr[3:0];
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_s_n);
   AST_AUTO_SEND: assert property (
      rep_vld && auto_tx_r && !tx_full_r && !poll_req |=> tx_full_r && tx_data_r == $past(rep_code))
      else $error("auto report not loaded for the host");
   AST_BUF_PUSH: assert property (
      rep_vld && !auto_tx_r && cnt_r < kpr_pkg::BUF_FULL_CNT && !op_hit
      |=> cnt_r == $past(cnt_r) + 4'h1 && buf_r[$past(wr_ptr_r)] == $past(rep_code))
      else $error("buffered report not stored");
   AST_POLL_MORE: assert property (
      poll_req && cnt_r != 4'h0 && !tx_full_r
      |=> tx_full_r && tx_data_r[7] == ($past(cnt_r) > 4'h1) &&
          cnt_r == $past(cnt_r) - 4'h1 + {3'h0, $past(push)})
      else $error("poll answer top bit wrong");
   AST_POLL_EMPTY: assert property (
      poll_req && cnt_r == 4'h0 && !tx_full_r |=> tx_data_r == 8'h00)
      else $error("empty poll not zero");
   AST_CLEAR: assert property (
      clr_req && !rep_vld |=> cnt_r == 4'h0 ##1 cnt_r <= 4'h1)
      else $error("buffer not emptied");
   AST_MODE_HOLD: assert property (
      arg_hit && opc_r == kpr_pkg::OP_RPT_MODE && cmd_byte == kpr_pkg::MODE_HOLD
      |=> hold_r && rpt_on_r)
      else $error("hold mode not taken");
   AST_HOLD_NO_RPT: assert property (
      hold_r && active_r && !release_ev |-> !rep_vld)
      else $error("repeat in hold mode");
   AST_CODES_END: assert property (
      code_hit && code_idx_r == kpr_pkg::CODE_LAST |=> state_r == kpr_pkg::KPR_IDLE)
      else $error("code table sequence overran");
   AST_FIRST_DELAY: assert property (
      rpt_fire && rpt_first_r |=> !rpt_first_r && rpt_cnt_r == 8'h00)
      else $error("first repeat did not rearm");
   AST_FULL_DROP: assert property (
      rep_vld && !auto_tx_r && cnt_r == kpr_pkg::BUF_FULL_CNT && !op_hit
      |=> cnt_r == kpr_pkg::BUF_FULL_CNT && $stable(wr_ptr_r) && irq_st_r[kpr_pkg::IRQ_DROP])
      else $error("full buffer accepted a key");
   AST_NO_RPT_OFF: assert property (
      !rpt_on_r && active_r |-> !rep_vld)
      else $error("repeat while repeat is off");
   COV_TYPEMATIC: cover property (rpt_fire && !rpt_first_r);
   COV_POLL_MORE: cover property (pop && cnt_r > 4'h1);
   COV_HOLD_UP: cover property (release_ev && hold_r && rpt_on_r);
   COV_DROP: cover property (drop);
endmodule

// ===== sim/kpr_host.sv
// Host model: classic single Wishbone cycles into the controller registers.
// Assumes a slave that acks each request once; only the bench watchdog ends a wait.
`timescale 1ns/1ps
module kpr_host (
   input wire logic clk,
   output logic wb_cyc,
   output logic wb_stb,
   output logic wb_we,
   output logic [4:0] wb_adr,
   output logic [3:0] wb_sel,
   output logic [31:0] wb_dat_wr,
   input wire logic [31:0] wb_dat_rd,
   input wire logic wb_ack
);
   initial begin
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 5'h00;
      wb_sel = 4'h0;
      wb_dat_wr = 32'h0;
   end
   task automatic xfer(input logic we, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_sel <= 4'hf;
      wb_dat_wr <= d;
      do begin
         @(posedge clk);
      end while (wb_ack !== 1'b1);
      q = wb_dat_rd;
      // Released lines show no stale value
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= ~we;
      wb_adr <= ~a;
      wb_sel <= 4'h0;
      wb_dat_wr <= ~d;
      @(posedge clk);
   endtask
endmodule

// ===== sim/tb.sv
// Self-checking bench for the keypad report controller.
// Assumes short unit counts so debounce and repeat fit a brief run.
`timescale 1ns/1ps
module tb;
   typedef struct {int k; logic [31:0] exp;} kpr_row_type;
   logic clk, rst_n, wb_cyc, wb_stb, wb_we, wb_ack, irq;
   logic [4:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_dat_wr, wb_dat_rd, v;
   logic [24:0] key_pressed;
   int miscompares, checks;
   kpr_row_type rows [3] = '{'{0, 32'h141}, '{12, 32'h14d}, '{24, 32'h159}};

   kpr_top #(.DEB_UNIT_CYC(4), .RPT_UNIT_CYC(20)) dut (.clk(clk), .rst_n(rst_n),
      .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
      .wb_dat_wr(wb_dat_wr), .wb_dat_rd(wb_dat_rd), .wb_ack(wb_ack),
      .key_pressed(key_pressed), .irq(irq));
   kpr_host h (.clk(clk), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
      .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_wr(wb_dat_wr), .wb_dat_rd(wb_dat_rd),
      .wb_ack(wb_ack));

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      h.xfer(1'b1, a, d, q);
   endtask
   task automatic reg_chk(input string n, input logic [4:0] a, input logic [31:0] e);
      h.xfer(1'b0, a, 32'h0, v);
      chk(n, e, v);
   endtask
   task automatic cmd(input logic [7:0] b);
      wr(kpr_pkg::REG_CMD, {24'h0, b});
   endtask
   task automatic op(input logic [7:0] o);
      cmd(kpr_pkg::CMD_PREFIX);
      cmd(o);
   endtask
   task automatic poll_chk(input logic [31:0] e);
      op(kpr_pkg::OP_POLL);
      reg_chk("poll", kpr_pkg::REG_TX, e);
   endtask
   // Hold time counts from the press; release also needs the settle time
   task automatic press(input int k, input int hold);
      key_pressed <= 25'h1 << k;
      repeat (hold) @(posedge clk);
      key_pressed <= 25'h0;
      repeat (50) @(posedge clk);
   endtask
   task automatic done(input string n);
      $display("test %s done", n);
   endtask
   task automatic results;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      results;
   end
   initial begin
      rst_n = 1'b0;
      key_pressed = 25'h0;
      miscompares = 0;
      checks = 0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      reg_chk("state", kpr_pkg::REG_STATE, 32'h03);
      reg_chk("cfg", kpr_pkg::REG_CFG, 32'h00020a08);
      reg_chk("unmapped", 5'h1c, 32'h0);
      chk("irq", 32'h0, {31'h0, irq});
      done("reset");
      foreach (rows[i]) begin
         press(rows[i].k, 60);
         reg_chk("tx", kpr_pkg::REG_TX, rows[i].exp);
      end
      reg_chk("status", kpr_pkg::REG_STATUS, 32'h3);
      done("auto");
      op(kpr_pkg::OP_AUTO_OFF);
      for (int i = 0; i < 11; i++) press(i, 45);
      reg_chk("state", kpr_pkg::REG_STATE, 32'ha2);
      wr(kpr_pkg::REG_IRQ_EN, 32'h8);
      chk("irq", 32'h1, {31'h0, irq});
      wr(kpr_pkg::REG_IRQ_CLR, 32'h8);
      chk("irq", 32'h0, {31'h0, irq});
      for (int i = 0; i < 10; i++) poll_chk({23'h0, 1'b1, i < 9, 7'(65 + i)});
      poll_chk(32'h100);
      press(5, 45);
      op(kpr_pkg::OP_CLR_BUF);
      poll_chk(32'h100);
      done("buffer");
      op(kpr_pkg::OP_TM_DELAY);
      cmd(8'h03);
      op(kpr_pkg::OP_TM_INTVL);
      cmd(8'h01);
      op(kpr_pkg::OP_DEBOUNCE);
      cmd(8'h04);
      reg_chk("cfg", kpr_pkg::REG_CFG, 32'h00010304);
      // Held about 90 cycles after settling: first report plus two repeats
      press(0, 90);
      reg_chk("state", kpr_pkg::REG_STATE, 32'h32);
      op(kpr_pkg::OP_CLR_BUF);
      op(kpr_pkg::OP_RPT_OFF);
      press(0, 90);
      reg_chk("state", kpr_pkg::REG_STATE, 32'h10);
      op(kpr_pkg::OP_CLR_BUF);
      op(kpr_pkg::OP_RPT_MODE);
      cmd(kpr_pkg::MODE_HOLD);
      press(3, 90);
      poll_chk(32'h1c4);
      poll_chk(32'h164);
      done("repeat");
      op(kpr_pkg::OP_RPT_MODE);
      cmd(kpr_pkg::MODE_TYPEMATIC);
      op(kpr_pkg::OP_AUTO_ON);
      op(kpr_pkg::OP_ASSIGN);
      for (int i = 0; i < 50; i++) cmd(i == 0 ? 8'h30 : kpr_pkg::KEEP_CODE);
      press(0, 40);
      reg_chk("tx", kpr_pkg::REG_TX, 32'h130);
      press(1, 40);
      reg_chk("tx", kpr_pkg::REG_TX, 32'h142);
      done("assign");
      results;
   end
endmodule
